// >>> logic/serial_host_block.sv
// Serial host block: SPI slave, SPI master and the I2C slave address phase.
// Control bits arrive as plain ports from the processor side; the SPI slave
// shift logic runs on the external serial clock, everything else on clock_i.
`timescale 1ns/1ps
module serial_host_block
	import serial_host_pkg::*;
#(
	parameter int FIFO_DEPTH = 8,
	parameter logic [ADDR_BITS-1:0] OWN_ADDR = 7'h10
)(
	// System clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Mode and configuration
	input wire logic interface_enable_i,
	input wire logic i2c_select_i,
	input wire logic master_select_i,
	input wire logic cpol_i,
	input wire logic cpha_i,
	input wire logic [7:0] clock_divider_i,
	input wire logic [1:0] word_len_i,
	input wire logic [1:0] request_enable_i,
	input wire logic bus_error_irq_enable_i,
	// Transmit holding register
	input wire logic tx_write_i,
	input wire logic [WORD_MAX-1:0] tx_data_i,
	output logic transmit_empty_o,
	// Receive FIFO
	input wire logic rx_read_i,
	output logic [WORD_MAX-1:0] rx_data_o,
	output logic receive_not_empty_o,
	// Status
	output logic bus_error_o,
	output logic bus_error_irq_o,
	output logic i2c_session_o,
	output logic i2c_read_o,
	// SPI pins; sck_i is the link clock in slave mode
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe_o,
	input wire logic miso_i,
	output logic miso_o,
	output logic miso_oe_o,
	input wire logic mosi_i,
	output logic mosi_o,
	output logic mosi_oe_o,
	input wire logic ss_n_i,
	// Host request pin
	input wire logic host_req_n_i,
	output logic host_req_n_o,
	output logic host_req_oe_o,
	// I2C pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o
);

	localparam int AW = $clog2(FIFO_DEPTH);
	localparam int W = WORD_MAX;

	// Refuse depths the pointer arithmetic cannot serve
	if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
	begin : g_depth_check
		$error("FIFO_DEPTH must be a power of two, at least 2");
	end

	// System-domain state
	typedef struct packed {
		logic [1:0] ss_s; // Select / address pin two synchroniser
		logic [1:0] a0_s; // Address pin zero synchroniser
		logic [1:0] scl_s; // I2C clock synchroniser
		logic [1:0] sda_s; // I2C data synchroniser
		logic [1:0] miso_s; // Master data input synchroniser
		logic [1:0] host_request_line_s; // Request input synchroniser
		logic scl_h; // Previous synchronised I2C clock
		logic sda_h; // Previous synchronised I2C data
		logic [2:0] done_s; // Word-done toggle sync and history
		logic [2:0] start_s; // Word-start toggle sync and history
		logic [W-1:0] hold; // Transmit holding register
		logic hold_full; // Holding register written, not yet moved
		logic [W-1:0] txw; // Slave shift word handed to the link
		logic [FIFO_DEPTH-1:0][W-1:0] mem; // Receive FIFO storage
		logic [AW:0] wp; // FIFO write pointer
		logic [AW:0] rp; // FIFO read pointer
		logic shift_ready; // Slave shifter between words
		logic tx_loaded; // Slave shifter loaded from holding
		logic host_request_line_n; // Request pin drive, active low
		logic host_request_line_oe; // Request pin is an output
		logic bus_err; // Sticky bus error
		logic irq; // Bus error interrupt request
		logic busy; // Master word in flight
		logic [7:0] div; // Master half-period counter
		logic [5:0] half; // Master half-period index
		logic sck; // Master serial clock
		logic mosi; // Master data out
		logic [W-1:0] mshift; // Master transmit shifter
		logic [W-1:0] mrx; // Master receive shifter
		i2c_state_t ist; // I2C slave state
		logic [3:0] bitc; // Address bits received
		logic [7:0] abyte; // Address byte
		logic sda_oe; // Pulling SDA low
		logic rd; // Session direction
		logic sess; // Session open
		logic spi_slave; // SPI slave mode active
		logic sck_oe; // Drive SCK
		logic mosi_oe; // Drive MOSI
		logic miso_oe; // Drive MISO
		logic [W-1:0] rdata; // FIFO head
		logic rne; // FIFO not empty
	} sys_t;

	// Link-domain data state
	typedef struct packed {
		logic [W-1:0] shift; // Slave transmit shifter
		logic [W-1:0] rxs; // Slave receive shifter
		logic [W-1:0] rxw; // Last complete received word
		logic done_tog; // Flips at each completed word
		logic start_tog; // Flips at each word's first clock
		logic miso; // Bit on MISO
	} lnk_t;

	sys_t s_q;
	sys_t s_d;
	lnk_t l_q;
	lnk_t l_d;
	logic [4:0] lcnt_q; // Slave bit counter, cleared by select
	logic [4:0] nb; // Bits per word
	logic link_clk; // Sample edge of the slave link is its rising edge
	logic link_clr; // Ends a slave word with the frame
	logic link_dclr; // Clears link data when the slave is off
	logic spi_sl;
	logic spi_ms;
	logic i2c_sl;
	logic done_evt;
	logic start_evt;
	logic fifo_full;
	logic load;
	logic start_m;
	logic tick;
	logic samp;
	logic lead;
	logic scl_rise;
	logic scl_fall;
	logic addr_match;
	logic [W-1:0] pword;

	// Mode decode
	assign spi_sl = interface_enable_i & ~i2c_select_i & ~master_select_i;
	assign spi_ms = interface_enable_i & ~i2c_select_i & master_select_i;
	assign i2c_sl = interface_enable_i & i2c_select_i & ~master_select_i;
	assign nb = word_bits(word_len_i);

	// Only phase and polarity pick the sampling edge
	assign link_clk = sck_i ^ (cpol_i ^ cpha_i);
	assign link_clr = ss_n_i | ~s_q.spi_slave;
	assign link_dclr = ~s_q.spi_slave;

	// Slave bit counter; select release aborts the word
	always_ff @(posedge link_clk or posedge link_clr)
	begin
		if (link_clr)
		begin
			lcnt_q <= 5'h00;
		end
		else
		begin
			lcnt_q <= (lcnt_q == nb - 5'h01) ? 5'h00 : lcnt_q + 5'h01;
		end
	end

	// Slave shift path: receive and transmit on each rising link clock edge
	always_comb
	begin
		l_d = l_q;
		l_d.rxs = (lcnt_q == 5'h00) ? {{(W-1){1'b0}}, mosi_i} : {l_q.rxs[W-2:0], mosi_i};
		if (lcnt_q == 5'h00)
		begin
			l_d.start_tog = ~l_q.start_tog;
		end
		if (lcnt_q == nb - 5'h01)
		begin
			// Word complete: publish it and take the next shift word
			l_d.rxw = l_d.rxs;
			l_d.done_tog = ~l_q.done_tog;
			l_d.shift = s_q.txw;
			l_d.miso = msb_of(s_q.txw, word_len_i);
		end
		else
		begin
			l_d.shift = l_q.shift << 1;
			l_d.miso = msb_of(l_q.shift << 1, word_len_i);
		end
	end

	// Link data registers
	always_ff @(posedge link_clk or posedge link_dclr)
	begin
		if (link_dclr)
		begin
			l_q <= '0;
		end
		else
		begin
			l_q <= l_d;
		end
	end

	// Events and conditions seen in the system domain
	assign done_evt = s_q.done_s[1] ^ s_q.done_s[2];
	assign start_evt = s_q.start_s[1] ^ s_q.start_s[2];
	assign fifo_full = (s_q.wp ^ s_q.rp) == {1'b1, {AW{1'b0}}};
	assign load = spi_sl & s_q.hold_full & (s_q.ss_s[1] | done_evt);
	assign start_m = spi_ms & ~s_q.busy & s_q.hold_full & ~s_q.bus_err
		& ((request_enable_i == RQE_OFF) | ~s_q.host_request_line_s[1]);
	assign tick = s_q.div == 8'h00;
	assign lead = ~s_q.half[0];
	assign samp = lead ^ cpha_i;
	assign scl_rise = s_q.scl_s[1] & ~s_q.scl_h;
	assign scl_fall = ~s_q.scl_s[1] & s_q.scl_h;
	assign addr_match = s_q.abyte[7:1] == own_address(OWN_ADDR, s_q.a0_s[1], s_q.ss_s[1]);
	// MISO reaches here two clocks late, so dividers below 2 would sample the previous bit
	assign pword = samp ? {s_q.mrx[W-2:0], s_q.miso_s[1]} : s_q.mrx;

	// Next state of the system domain
	always_comb
	begin
		s_d = s_q;
		// Pin and toggle synchronisers
		s_d.ss_s = {s_q.ss_s[0], ss_n_i};
		s_d.a0_s = {s_q.a0_s[0], mosi_i};
		s_d.scl_s = {s_q.scl_s[0], scl_i};
		s_d.sda_s = {s_q.sda_s[0], sda_i};
		s_d.miso_s = {s_q.miso_s[0], miso_i};
		s_d.host_request_line_s = {s_q.host_request_line_s[0], host_req_n_i};
		s_d.done_s = {s_q.done_s[1:0], l_q.done_tog};
		s_d.start_s = {s_q.start_s[1:0], l_q.start_tog};
		s_d.scl_h = s_q.scl_s[1];
		s_d.sda_h = s_q.sda_s[1];
		s_d.spi_slave = spi_sl;
		// FIFO read
		if (rx_read_i && s_q.wp != s_q.rp)
		begin
			s_d.rp = s_q.rp + 1'b1;
		end
		// Slave: move holding word to the shifter between words
		if (load)
		begin
			s_d.txw = s_q.hold;
			s_d.hold_full = 1'b0;
			s_d.tx_loaded = 1'b1;
		end
		// Slave: store completed words while room remains
		if (spi_sl && done_evt && !fifo_full)
		begin
			s_d.mem[s_q.wp[AW-1:0]] = l_q.rxw;
			s_d.wp = s_q.wp + 1'b1;
		end
		// Slave request flags; word start drops both
		if (done_evt || s_q.ss_s[1])
		begin
			s_d.shift_ready = 1'b1;
		end
		if (start_evt)
		begin
			s_d.shift_ready = 1'b0;
			s_d.tx_loaded = 1'b0;
		end
		// Request pin per enable field
		unique case (request_enable_i)
			RQE_RX: s_d.host_request_line_n = ~(spi_sl & s_d.shift_ready & ~fifo_full);
			RQE_TX: s_d.host_request_line_n = ~(spi_sl & s_d.tx_loaded);
			RQE_BOTH: s_d.host_request_line_n = ~(spi_sl & s_d.shift_ready & ~fifo_full & s_d.tx_loaded);
			RQE_OFF: s_d.host_request_line_n = 1'b1;
		endcase
		s_d.host_request_line_oe = spi_sl | i2c_sl;
		// Master: select asserted is a bus error
		if (spi_ms && !s_q.ss_s[1])
		begin
			s_d.bus_err = 1'b1;
		end
		s_d.irq = s_d.bus_err & bus_error_irq_enable_i;
		// Master word engine
		if (start_m)
		begin
			s_d.busy = 1'b1;
			s_d.mshift = s_q.hold;
			s_d.hold_full = 1'b0;
			s_d.mosi = cpha_i ? s_q.mosi : msb_of(s_q.hold, word_len_i);
			s_d.mrx = '0;
			s_d.half = 6'h00;
			s_d.div = clock_divider_i;
		end
		else if (s_q.busy)
		begin
			s_d.div = tick ? clock_divider_i : s_q.div - 8'h01;
			if (tick)
			begin
				s_d.sck = ~s_q.sck;
				s_d.half = s_q.half + 6'h01;
				if (samp)
				begin
					s_d.mrx = pword;
				end
				else
				begin
					s_d.mshift = s_q.mshift << 1;
					s_d.mosi = cpha_i ? msb_of(s_q.mshift, word_len_i) : msb_of(s_q.mshift << 1, word_len_i);
				end
				if (s_q.half == 6'({nb, 1'b0} - 6'h01))
				begin
					s_d.busy = 1'b0;
					if (!fifo_full)
					begin
						s_d.mem[s_q.wp[AW-1:0]] = pword;
						s_d.wp = s_q.wp + 1'b1;
					end
				end
			end
		end
		else
		begin
			s_d.sck = cpol_i;
		end
		s_d.sck_oe = spi_ms;
		s_d.mosi_oe = spi_ms;
		s_d.miso_oe = spi_sl & ~s_q.ss_s[1];
		// I2C slave address phase
		if (!i2c_sl)
		begin
			s_d.ist = I_IDLE;
			s_d.sda_oe = 1'b0;
			s_d.sess = 1'b0;
		end
		else if (s_q.scl_s[1] && s_q.scl_h && s_q.sda_h && !s_q.sda_s[1])
		begin
			s_d.ist = I_ADDR;
			s_d.bitc = 4'h0;
			s_d.sda_oe = 1'b0;
			s_d.sess = 1'b0;
		end
		else if (s_q.scl_s[1] && s_q.scl_h && !s_q.sda_h && s_q.sda_s[1])
		begin
			s_d.ist = I_IDLE;
			s_d.sda_oe = 1'b0;
			s_d.sess = 1'b0;
		end
		else
		begin
			unique case (s_q.ist)
				I_IDLE: s_d.sda_oe = 1'b0;
				I_ADDR:
				begin
					if (scl_rise)
					begin
						s_d.abyte = {s_q.abyte[6:0], s_q.sda_s[1]};
						s_d.bitc = s_q.bitc + 4'h1;
					end
					else if (scl_fall && s_q.bitc == BYTE_BITS)
					begin
						s_d.sda_oe = addr_match;
						s_d.ist = addr_match ? I_ACK : I_IDLE;
					end
				end
				I_ACK:
				begin
					if (scl_fall)
					begin
						s_d.sda_oe = 1'b0;
						s_d.sess = 1'b1;
						s_d.rd = s_q.abyte[0];
						s_d.ist = I_SESS;
					end
				end
				I_SESS: s_d.sda_oe = 1'b0;
			endcase
		end
		// Outputs from the settled FIFO
		s_d.rdata = s_d.mem[s_d.rp[AW-1:0]];
		s_d.rne = s_d.wp != s_d.rp;
		// Individual reset while the enable is clear
		if (rst_i || !interface_enable_i)
		begin
			s_d = '0;
			s_d.ss_s = 2'h3;
			s_d.host_request_line_s = 2'h3;
			s_d.host_request_line_n = 1'b1;
		end
		// A write lands whenever enabled and out of reset, even in the cycle of a move
		if (tx_write_i && !rst_i && interface_enable_i)
		begin
			s_d.hold = tx_data_i;
			s_d.hold_full = 1'b1;
		end
	end

	// System registers
	always_ff @(posedge clock_i)
	begin
		s_q <= s_d;
	end

	// Outputs
	assign transmit_empty_o = ~s_q.hold_full;
	assign rx_data_o = s_q.rdata;
	assign receive_not_empty_o = s_q.rne;
	assign bus_error_o = s_q.bus_err;
	assign bus_error_irq_o = s_q.irq;
	assign i2c_session_o = s_q.sess;
	assign i2c_read_o = s_q.rd;
	assign sck_o = s_q.sck;
	assign sck_oe_o = s_q.sck_oe;
	assign miso_o = l_q.miso;
	assign miso_oe_o = s_q.miso_oe;
	assign mosi_o = s_q.mosi;
	assign mosi_oe_o = s_q.mosi_oe;
	assign host_req_n_o = s_q.host_request_line_n;
	assign host_req_oe_o = s_q.host_request_line_oe;
	assign sda_o = 1'b0 & s_q.sda_oe;
	assign sda_oe_o = s_q.sda_oe;

	// Checks, all in the system domain
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	a_mode_req_idle: assert property (!(spi_sl && request_enable_i != RQE_OFF) |=> host_req_n_o)
		else $error("request asserted outside SPI slave mode");
	a_disable_clears: assert property (!interface_enable_i |=> !receive_not_empty_o && !bus_error_o)
		else $error("disable did not clear state");
	a_start_drops_req: assert property (start_evt |=> host_req_n_o)
		else $error("request not dropped at word start");
	a_select_error: assert property (spi_ms && interface_enable_i && !s_q.ss_s[1] |=> bus_error_o)
		else $error("bus error not set");
	a_error_irq: assert property (bus_error_irq_o == (bus_error_o && $past(bus_error_irq_enable_i)))
		else $error("bus error interrupt missing");
	a_start_after_write: assert property ($rose(s_q.busy)
		|-> $past(s_q.hold_full) && (transmit_empty_o != $past(tx_write_i)))
		else $error("master started without a written word");
	a_request_gate: assert property ($rose(s_q.busy) && request_enable_i != RQE_OFF
		|-> !$past(s_q.host_request_line_s[1]))
		else $error("master clocked without request");
	a_nack_release: assert property (i2c_sl && s_q.ist == I_ADDR && scl_fall && s_q.bitc == BYTE_BITS
		&& !addr_match && interface_enable_i |=> !sda_oe_o && s_q.ist == I_IDLE)
		else $error("mismatch was acknowledged");
	a_ack_drive: assert property (i2c_sl && s_q.ist == I_ADDR && scl_fall && s_q.bitc == BYTE_BITS
		&& addr_match && interface_enable_i |=> sda_oe_o ##1 sda_oe_o)
		else $error("match not acknowledged");
	a_slave_store: assert property (spi_sl && done_evt && !fifo_full && interface_enable_i
		|=> receive_not_empty_o)
		else $error("received word not stored");

	c_master_word: cover property ($fell(s_q.busy));
	c_slave_word: cover property (done_evt && spi_sl);
	c_i2c_ack: cover property ($rose(sda_oe_o));

endmodule : serial_host_block

// >>> logic/serial_host_pkg.sv
// Shared constants, types and helpers of the serial host block.
// Assumes one system clock domain plus the SPI link clock of the slave path.
// Notes on behaviour
// - Mode from enable, bus select, master select.
// - Clearing enable resets the whole interface.
// - SPI slave uses only phase, polarity.
// - SPI slave: clock, MOSI, select in; MISO, request out.
// - SPI always full duplex, both paths' flags live.
// - Slave loads holding word between words, else repeats.
// - Received words enter FIFO; empty/non-empty flags shown.
// - Slave request: receive ready, transmit loaded, or both.
// - Slave request drops at next word's first clock.
// - Select released mid-word aborts, discards partial word.
// - SPI master: clock, MOSI out; MISO, select, request in.
// - Master sees select asserted: bus error, optional interrupt.
// - Master transfer starts only after holding register write.
// - Master ignores request input when field zero.
// - Honoured request gates each whole master word.
// - Request handshake only with clock phase one; the master gates on the request with either phase.
// - Reset before receiving empties the receive FIFO.
// - I2C slave ignores clock control; pin roles fixed.
// - I2C slave detects start, then receives address.
// - Address mismatch: leave data released, await start.
// - Address match: pull data low, start session.
// - Address byte: seven address bits, one direction.
// - Direction zero receives, direction one transmits.
package serial_host_pkg;

	// Widest word and word-length codes
	localparam int WORD_MAX = 24;
	localparam logic [1:0] WL_8 = 2'h0;
	localparam logic [1:0] WL_16 = 2'h1;
	localparam logic [4:0] BITS_8 = 5'h08;
	localparam logic [4:0] BITS_16 = 5'h10;
	localparam logic [4:0] BITS_24 = 5'h18;

	// Request enable field codes
	localparam logic [1:0] RQE_OFF = 2'h0;
	localparam logic [1:0] RQE_RX = 2'h1;
	localparam logic [1:0] RQE_TX = 2'h2;
	localparam logic [1:0] RQE_BOTH = 2'h3;

	// I2C address byte layout
	localparam int ADDR_BITS = 7;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam int ADDR_POS_A0 = 0;
	localparam int ADDR_POS_A2 = 2;

	// Clock of the system domain
	localparam int CLK_PERIOD_NS = 10;

	// I2C slave address phase
	typedef enum logic [1:0] {I_IDLE, I_ADDR, I_ACK, I_SESS} i2c_state_t;

	// Bits per word for a word-length code
	function automatic logic [4:0] word_bits(input logic [1:0] wl);
		if (wl == WL_8)
		begin
			return BITS_8;
		end
		else if (wl == WL_16)
		begin
			return BITS_16;
		end
		return BITS_24;
	endfunction : word_bits

	// Bit that goes out first for the word length
	function automatic logic msb_of(input logic [WORD_MAX-1:0] w, input logic [1:0] wl);
		return w[word_bits(wl) - 5'h01];
	endfunction : msb_of

	// Own address with the two pin bits substituted
	function automatic logic [ADDR_BITS-1:0] own_address(input logic [ADDR_BITS-1:0] base,
		input logic a0, input logic a2);
		logic [ADDR_BITS-1:0] r;
		r = base;
		r[ADDR_POS_A0] = a0;
		r[ADDR_POS_A2] = a2;
		return r;
	endfunction : own_address

endpackage : serial_host_pkg

// >>> tb/serial_host_block_tb.sv
// Self-checking bench of the serial host block against the far-side model.
// Assumes the package constants and the block's default parameters.
`timescale 1ns/1ps
module serial_host_block_tb
	import serial_host_pkg::*;
;
	// Bench-driven inputs
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic en = 1'b0;
	logic i2c = 1'b0;
	logic mst = 1'b0;
	logic cpha = 1'b0;
	logic cpol = 1'b0;
	logic [7:0] div = 8'h03; // Master half period of four clocks, above the MISO sync delay
	logic [1:0] wl = WL_8;
	logic [1:0] rqe = RQE_OFF;
	logic bie = 1'b0;
	logic txw = 1'b0;
	logic [WORD_MAX-1:0] txd = 24'h000000;
	logic rxr = 1'b0;
	int err_count = 0;
	int checked = 0;
	logic ack;
	// Block outputs
	logic tx_empty, rx_ne, ber, ber_irq, sess, rd;
	logic [WORD_MAX-1:0] rx_data;
	logic sck, sck_oe, miso, miso_oe, mosi, mosi_oe, req_n, req_oe, sda, sda_oe;
	// Far-side lines; SDA is pulled up unless someone pulls it low
	logic f_sck, f_mosi, f_ss_n, f_miso, f_req_n, f_scl, f_sda;
	wire logic sda_line;
	assign sda_line = f_sda & ~sda_oe;

	// System clock, 100 MHz
	initial
	begin
		forever #5 clock_i = ~clock_i;
	end

	serial_host_block uut (.clock_i(clock_i), .rst_i(rst_i), .interface_enable_i(en), .i2c_select_i(i2c),
		.master_select_i(mst), .cpol_i(cpol), .cpha_i(cpha), .clock_divider_i(div), .word_len_i(wl),
		.request_enable_i(rqe), .bus_error_irq_enable_i(bie), .tx_write_i(txw), .tx_data_i(txd),
		.transmit_empty_o(tx_empty), .rx_read_i(rxr), .rx_data_o(rx_data), .receive_not_empty_o(rx_ne),
		.bus_error_o(ber), .bus_error_irq_o(ber_irq), .i2c_session_o(sess), .i2c_read_o(rd), .sck_i(f_sck),
		.sck_o(sck), .sck_oe_o(sck_oe), .miso_i(f_miso), .miso_o(miso), .miso_oe_o(miso_oe), .mosi_i(f_mosi),
		.mosi_o(mosi), .mosi_oe_o(mosi_oe), .ss_n_i(f_ss_n), .host_req_n_i(f_req_n), .host_req_n_o(req_n),
		.host_req_oe_o(req_oe), .scl_i(f_scl), .sda_i(sda_line), .sda_o(sda), .sda_oe_o(sda_oe));

	spi_far_model far (.sck_o(f_sck), .mosi_o(f_mosi), .ss_n_o(f_ss_n), .miso_o(f_miso), .req_n_o(f_req_n),
		.scl_o(f_scl), .sda_o(f_sda), .cpha_i(cpha), .miso_i(miso), .mck_i(sck), .mosi_i(mosi),
		.line_i(sda_line));

	// Compare and count
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(negedge clock_i);
	endtask : cyc

	// Individual reset, then a new mode
	task automatic setup(input logic s_i2c, input logic s_mst, input logic [1:0] s_rqe, input logic s_cpha);
		en = 1'b0;
		cyc(2);
		i2c = s_i2c;
		mst = s_mst;
		rqe = s_rqe;
		cpha = s_cpha;
		en = 1'b1;
		cyc(4);
	endtask : setup

	task automatic write(input logic [23:0] d);
		txd = d;
		txw = 1'b1;
		cyc(1);
		txw = 1'b0;
	endtask : write

	task automatic pop();
		rxr = 1'b1;
		cyc(1);
		rxr = 1'b0;
	endtask : pop

	// Bounded wait for a received word
	task automatic wait_rx();
		int k;
		for (k = 0; k < 400 && rx_ne !== 1'b1; k++)
		begin
			cyc(1);
		end
	endtask : wait_rx

	// Slave words, staging of the holding word, word lengths
	task automatic t_slave();
		setup(1'b0, 1'b0, RQE_OFF, 1'b0);
		check({sck_oe, mosi_oe, req_oe, miso_oe}, 24'h2);
		write(24'h0000A5);
		check(tx_empty, 1'b0);
		cyc(2);
		check(tx_empty, 1'b1);
		far.spi_word(24'h00003C, 8, 8);
		cyc(10);
		check(far.got_s[7:0], 8'h00);
		check(rx_ne, 1'b1);
		far.spi_word(24'h000081, 8, 8);
		cyc(10);
		check(far.got_s[7:0], 8'hA5);
		check(rx_data, 24'h00003C);
		pop();
		check(rx_data, 24'h000081);
		wl = WL_16;
		setup(1'b0, 1'b0, RQE_OFF, 1'b0);
		check(rx_ne, 1'b0);
		far.spi_word(24'h00C35A, 16, 16);
		cyc(10);
		check(rx_data, 24'h00C35A);
		wl = 2'h2;
		setup(1'b0, 1'b0, RQE_OFF, 1'b0);
		far.spi_word(24'hA1B2C3, 24, 24);
		cyc(10);
		check(rx_data, 24'hA1B2C3);
		wl = WL_8;
	endtask : t_slave

	// Select released mid-word, then a clean word
	task automatic t_abort();
		setup(1'b0, 1'b0, RQE_OFF, 1'b0);
		far.spi_word(24'h0000FF, 8, 4);
		far.release_sel();
		cyc(10);
		check(rx_ne, 1'b0);
		far.spi_word(24'h000066, 8, 8);
		cyc(10);
		check(rx_data, 24'h000066);
	endtask : t_abort

	// Every request code, before and after a holding write, then the drop
	task automatic t_request();
		int c;
		for (c = 0; c < 4; c++)
		begin
			setup(1'b0, 1'b0, c[1:0], 1'b1);
			check(req_n, c != 1);
			write(24'h000001);
			cyc(4);
			check(req_n, c == 0);
		end
		far.spi_word(24'h000000, 8, 1);
		cyc(6);
		check(req_n, 1'b1);
		far.release_sel();
	endtask : t_request

	// Master transfers, with and without the request handshake
	task automatic t_master();
		far.req(1'b1);
		far.load(8'h5A);
		setup(1'b0, 1'b1, RQE_OFF, 1'b0);
		check({sck_oe, mosi_oe, req_oe}, 24'h6);
		cyc(30);
		check(rx_ne, 1'b0);
		write(24'h0000C3);
		wait_rx();
		check(rx_data, 24'h00005A);
		check(far.got_m[7:0], 8'hC3);
		check(tx_empty, 1'b1);
		far.load(8'h33);
		div = 8'h05;
		setup(1'b0, 1'b1, RQE_RX, 1'b1);
		write(24'h000096);
		cyc(100);
		check(rx_ne, 1'b0);
		far.req(1'b0);
		wait_rx();
		check(rx_data, 24'h000033);
		write(24'h000001);
		cyc(100);
		check(tx_empty, 1'b0);
	endtask : t_master

	// Select asserted in master mode, interrupt enable, individual reset
	task automatic t_bus_error();
		bie = 1'b0;
		cpol = 1'b1;
		setup(1'b0, 1'b1, RQE_OFF, 1'b0);
		check(sck, 1'b1);
		far.pins(1'b1, 1'b0);
		cyc(6);
		check({ber, ber_irq}, 24'h2);
		bie = 1'b1;
		cyc(3);
		check({ber, ber_irq}, 24'h3);
		far.pins(1'b1, 1'b1);
		cyc(3);
		check(ber, 1'b1);
		en = 1'b0;
		cyc(3);
		check(ber, 1'b0);
		bie = 1'b0;
		cpol = 1'b0;
	endtask : t_bus_error

	// Address phase: match read, base address without pin bits, match write
	task automatic t_i2c();
		far.pins(1'b1, 1'b1);
		setup(1'b1, 1'b0, RQE_OFF, 1'b0);
		check({sda, sda_oe}, 24'h0);
		far.i2c_addr(8'h2B, ack);
		check(ack, 1'b1);
		check({sess, rd}, 24'h3);
		setup(1'b1, 1'b0, RQE_OFF, 1'b1);
		far.i2c_addr(8'h20, ack);
		check(ack, 1'b0);
		check(sess, 1'b0);
		far.i2c_addr(8'h2A, ack);
		check(ack, 1'b1);
		check({sess, rd}, 24'h2);
	endtask : t_i2c

	// Verdict and end of run
	task automatic complete_run();
		if (err_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	// Main sequence
	initial
	begin
		cyc(20);
		rst_i = 1'b0;
		check({tx_empty, rx_ne, req_n, ber}, 24'hA);
		t_slave();
		t_abort();
		t_request();
		t_master();
		t_bus_error();
		t_i2c();
		complete_run();
	end

	// Hang guard, well beyond the expected run
	initial
	begin
		#400000;
		err_count++;
		complete_run();
	end
endmodule : serial_host_block_tb

// >>> tb/spi_far_model.sv
// Far-side model: SPI master toward the slave path, SPI slave for the master path, I2C master.
// Assumes the bench calls one of its tasks at a time; cpol is zero in every transfer it takes part in.
`timescale 1ns/1ps
module spi_far_model
(
	// Lines toward the block
	output logic sck_o,
	output logic mosi_o,
	output logic ss_n_o,
	output logic miso_o,
	output logic req_n_o,
	output logic scl_o,
	output logic sda_o,
	// Lines from the block
	input wire logic cpha_i,
	input wire logic miso_i,
	input wire logic mck_i,
	input wire logic mosi_i,
	input wire logic line_i
);
	logic [23:0] got_s = 24'h000000; // Caught from the slave path
	logic [23:0] got_m = 24'h000000; // Caught from the master path
	logic [7:0] word_q = 8'h00; // Word sent toward the master path

	// Idle levels: link clock low, select and request released
	initial
	begin
		{sck_o, mosi_o, ss_n_o, miso_o, req_n_o, scl_o, sda_o} = 7'h37;
	end

	// Leading edge of the master clock: drop request, shift for phase one, catch for phase zero
	always @(posedge mck_i)
	begin
		req_n_o <= 1'b1;
		if (cpha_i)
		begin
			miso_o <= word_q[7];
			word_q <= word_q << 1;
		end
		else
		begin
			got_m <= {got_m[22:0], mosi_i};
		end
	end

	// Trailing edge: next bit for phase zero, catch for phase one
	always @(negedge mck_i)
	begin
		if (cpha_i)
		begin
			got_m <= {got_m[22:0], mosi_i};
		end
		else
		begin
			miso_o <= word_q[6];
			word_q <= word_q << 1;
		end
	end

	// Catch the slave's output on the rising link clock
	always @(posedge sck_o)
	begin
		got_s <= {got_s[22:0], miso_i};
	end

	// One word MSB first at 64 ns a bit; select stays low when stopped early
	task automatic spi_word(input logic [23:0] w, input int n, input int stop);
		int i;
		ss_n_o = 1'b0;
		#23;
		for (i = 0; i < stop; i++)
		begin
			mosi_o = w[n - 1 - i];
			#32;
			sck_o = 1'b1;
			#32;
			sck_o = 1'b0;
		end
		if (stop == n)
		begin
			#32;
			release_sel();
		end
	endtask : spi_word

	// Release select; the data line no longer shows the last bit
	task automatic release_sel();
		ss_n_o = 1'b1;
		mosi_o = ~mosi_o;
	endtask : release_sel

	// Word for the master path, first bit ready before the first edge
	task automatic load(input logic [7:0] w);
		word_q = w;
		miso_o = w[7];
	endtask : load

	// Request line of the external slave, low means ready
	task automatic req(input logic v);
		req_n_o = v;
	endtask : req

	// Address pins shared with the SPI lines
	task automatic pins(input logic a0, input logic a2);
		mosi_o = a0;
		ss_n_o = a2;
	endtask : pins

	// Start, address byte, ninth clock; ack is true when SDA was held low
	task automatic i2c_addr(input logic [7:0] b, output logic ack);
		int i;
		scl_o = 1'b1;
		#400;
		sda_o = 1'b0;
		#400;
		scl_o = 1'b0;
		for (i = 7; i >= 0; i--)
		begin
			sda_o = b[i];
			#200;
			scl_o = 1'b1;
			#400;
			scl_o = 1'b0;
			#200;
		end
		sda_o = 1'b1;
		#200;
		scl_o = 1'b1;
		#200;
		ack = ~line_i;
		#200;
		scl_o = 1'b0;
		#400;
	endtask : i2c_addr
endmodule : spi_far_model
